// >>> cbld_map.vh
`ifndef CBLD_MAP_VH
`define CBLD_MAP_VH
// ==========================================================
// register byte offsets
`define CBLD_OFF_CTRL     8'h00
`define CBLD_OFF_FREQ     8'h04
`define CBLD_OFF_HUE0     8'h08
`define CBLD_OFF_HUE1     8'h0C
`define CBLD_OFF_BLVL     8'h10
`define CBLD_OFF_CORE     8'h14
`define CBLD_OFF_LERR     8'h18
`define CBLD_OFF_STAT     8'h44
// ==========================================================
// control register field positions
`define CBLD_CTRL_PAL     0
`define CBLD_CTRL_DBYP    1
`define CBLD_CTRL_FBYP    2
`define CBLD_CTRL_FSEL    3
`define CBLD_CTRL_COREN   4
`define CBLD_CTRL_SET2    5
`define CBLD_CTRL_NFLO    6
`define CBLD_CTRL_NFHI    7
// status register field positions
`define CBLD_STAT_PRES    0
`define CBLD_STAT_FLO     1
`define CBLD_STAT_FHI     3
`define CBLD_STAT_KILL    4
// ==========================================================
// reset values
`define CBLD_RST_CTRL     8'h00
`define CBLD_RST_FREQ     32'h2000_0000
`define CBLD_RST_HUE      16'h0000
`define CBLD_RST_BLVL     8'h10
`define CBLD_RST_CORE     4'h0
// ==========================================================
// counts, lines and table phases
`define CBLD_KILL_LINES   7'h7F
`define CBLD_LINE_309     10'h135
`define CBLD_LINE_7       10'h007
`define CBLD_LINE_258     10'h102
`define CBLD_LINE_259     10'h103
`define CBLD_PH_QUARTER   6'h10
`define CBLD_PH_HALF      6'h20
`endif

// >>> cbld_top.v
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "cbld_map.vh"

// Overview of operation
// - demodulate chroma by sine/cosine, then low-pass
// - burst error steers synthesizer frequency only
// - phase converted to sine/cosine by table
// - phase-advance line flag advances cosine phase
// - line kill flag when U,V burst low
// - count burstless lines; 127 arms kill
// - kill: pass video as luma, black chroma
// - kill ends after field under 127 lines
// - color-present status bit at 44h
// - field parity from vsync half-line position
// - NTSC frame bit from phase at detect
// - PAL frame bit forced by pattern, flywheels
// - 625-line pattern uses line 309 burst
// - second pattern uses lines 258/259
// - frame bit low frames 0/2, high 1/3
// - color frame bit: NTSC low, PAL phase
// - hue offset added in active video only
// - loop error captured per line, readable
// - demodulator bypass skips demodulation
// - filter bypass skips demodulation low-pass
// - coring zeroes chroma under threshold
module cbld_top (
    input  wire               clk,
    input  wire               sys_rst,
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [7:0]         paddr,
    input  wire [31:0]        pwdata,
    output reg  [31:0]        prdata,
    output wire               pready,
    output wire               pslverr,
    input  wire signed [9:0]  chroma_in,
    input  wire signed [9:0]  cr_in,
    input  wire [9:0]         luma_in,
    input  wire [9:0]         video_in,
    input  wire [9:0]         line_count,
    input  wire [10:0]        pixel_count,
    input  wire               burst_gate,
    input  wire               active_video,
    input  wire               vsync_second_half,
    input  wire               hue_select,
    output reg  [9:0]         luma_out,
    output reg  signed [10:0] u_out,
    output reg  signed [10:0] v_out,
    output reg  [2:0]         field_sequence_count,
    output reg                phase_advance_line_flag,
    output reg                color_kill_active
);

// ==========================================================
// functions
// quarter-wave sine table, full wave by symmetry
function signed [8:0] cbld_sin;
    input [5:0] p;
    reg   [3:0] i;
    reg   [7:0] m;
    begin
        i = p[4] ? ~p[3:0] : p[3:0];
        case (i)
            4'h0: m = 8'h0D;
            4'h1: m = 8'h25;
            4'h2: m = 8'h3E;
            4'h3: m = 8'h56;
            4'h4: m = 8'h6D;
            4'h5: m = 8'h83;
            4'h6: m = 8'h98;
            4'h7: m = 8'hAB;
            4'h8: m = 8'hBD;
            4'h9: m = 8'hCD;
            4'hA: m = 8'hDB;
            4'hB: m = 8'hE7;
            4'hC: m = 8'hF0;
            4'hD: m = 8'hF7;
            4'hE: m = 8'hFC;
            default: m = 8'hFF;
        endcase
        cbld_sin = p[5] ? -$signed({1'b0, m}) : $signed({1'b0, m});
    end
endfunction

// sign extension 11 to 15 bits
function signed [14:0] cbld_sx;
    input signed [10:0] a;
    begin
        cbld_sx = {{4{a[10]}}, a};
    end
endfunction

// gaussian low-pass: 1-2-1 or 1-4-6-4-1
function signed [10:0] cbld_lpf;
    input              sel;
    input signed [10:0] a;
    input signed [10:0] b;
    input signed [10:0] c;
    input signed [10:0] d;
    input signed [10:0] e;
    reg   signed [14:0] s;
    begin
        s = 15'h0000;
        if (sel) begin
            s = cbld_sx(a) + (cbld_sx(b) <<< 2) + (cbld_sx(c) <<< 2)
                + (cbld_sx(c) <<< 1) + (cbld_sx(d) <<< 2) + cbld_sx(e);
            cbld_lpf = s[14:4];
        end else begin
            s = cbld_sx(a) + (cbld_sx(b) <<< 1) + cbld_sx(c);
            cbld_lpf = s[12:2];
        end
    end
endfunction

// magnitude of an 11-bit signed sample
function [10:0] cbld_abs;
    input signed [10:0] x;
    begin
        cbld_abs = x[10] ? -x : x;
    end
endfunction

// coring: small magnitudes forced to zero
function signed [10:0] cbld_core;
    input              en;
    input [3:0]        thr;
    input signed [10:0] x;
    begin
        if (en && (cbld_abs(x) < {7'h00, thr}))
            cbld_core = 11'h000;
        else
            cbld_core = x;
    end
endfunction

// ==========================================================
// register file over apb
reg  [7:0]  ctrl;
reg  [31:0] freq;
reg  [15:0] hue0;
reg  [15:0] hue1;
reg  [7:0]  blvl;
reg  [3:0]  core_thr;
reg  [7:0]  loop_err;
reg  [31:0] next_rdata;
reg         hit;

wire pal      = ctrl[`CBLD_CTRL_PAL];
wire apb_wr   = psel & penable & pwrite;
wire apb_set  = psel & ~penable;
wire color_present_status = ~color_kill_active;

assign pready  = 1'b1;
assign pslverr = psel & penable & ~hit;

// read mux and address decode
always @* begin
    next_rdata = 32'h0000_0000;
    hit        = 1'b1;
    if (paddr == `CBLD_OFF_CTRL) begin
        next_rdata = {24'h000000, ctrl};
    end else if (paddr == `CBLD_OFF_FREQ) begin
        next_rdata = freq;
    end else if (paddr == `CBLD_OFF_HUE0) begin
        next_rdata = {16'h0000, hue0};
    end else if (paddr == `CBLD_OFF_HUE1) begin
        next_rdata = {16'h0000, hue1};
    end else if (paddr == `CBLD_OFF_BLVL) begin
        next_rdata = {24'h000000, blvl};
    end else if (paddr == `CBLD_OFF_CORE) begin
        next_rdata = {28'h0000000, core_thr};
    end else if (paddr == `CBLD_OFF_LERR) begin
        next_rdata = {24'h000000, loop_err};
    end else if (paddr == `CBLD_OFF_STAT) begin
        next_rdata = {27'h0000000, color_kill_active,
                      field_sequence_count, color_present_status};
    end else begin
        hit = 1'b0;
    end
end

// register writes and read data capture
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        ctrl     <= `CBLD_RST_CTRL;
        freq     <= `CBLD_RST_FREQ;
        hue0     <= `CBLD_RST_HUE;
        hue1     <= `CBLD_RST_HUE;
        blvl     <= `CBLD_RST_BLVL;
        core_thr <= `CBLD_RST_CORE;
        prdata   <= 32'h0000_0000;
    end else begin
        if (apb_set)
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        if (apb_wr) begin
            if (paddr == `CBLD_OFF_CTRL)
                ctrl <= pwdata[7:0];
            else if (paddr == `CBLD_OFF_FREQ)
                freq <= pwdata;
            else if (paddr == `CBLD_OFF_HUE0)
                hue0 <= pwdata[15:0];
            else if (paddr == `CBLD_OFF_HUE1)
                hue1 <= pwdata[15:0];
            else if (paddr == `CBLD_OFF_BLVL)
                blvl <= pwdata[7:0];
            else if (paddr == `CBLD_OFF_CORE)
                core_thr <= pwdata[3:0];
        end
    end
end

// ==========================================================
// timing events
wire line_start  = (pixel_count == 11'h000);
wire field_start = (line_count == 10'h000) &&
                   (pixel_count == {9'h000, ctrl[`CBLD_CTRL_NFHI:`CBLD_CTRL_NFLO]});
reg  burst_d;
wire burst_end   = burst_d & ~burst_gate;

// ==========================================================
// subcarrier synthesizer and burst loop
reg  [31:0]        phase;
reg  signed [31:0] freq_adj;
reg  signed [19:0] err_acc;
wire [31:0]        hue_off = active_video ?
                             {(hue_select ? hue1 : hue0), 16'h0000} : 32'h0000_0000;
wire [31:0]        demod_ph = phase + hue_off;
wire [5:0]         sin_idx  = demod_ph[31:26];
wire [5:0]         cos_idx  = sin_idx + `CBLD_PH_QUARTER +
                              (phase_advance_line_flag ? `CBLD_PH_HALF : 6'h00);
wire signed [8:0]  sin_v    = cbld_sin(sin_idx);
wire signed [8:0]  cos_v    = cbld_sin(cos_idx);
wire signed [18:0] u_prod   = chroma_in * sin_v;
wire signed [18:0] v_prod   = chroma_in * cos_v;
wire signed [10:0] u_mix    = u_prod[18:8];
wire signed [10:0] v_mix    = v_prod[18:8];
wire signed [19:0] v_ext    = {{9{v_mix[10]}}, v_mix};

// oscillator with integral frequency correction only
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        phase    <= 32'h0000_0000;
        freq_adj <= 32'h0000_0000;
        err_acc  <= 20'h00000;
        loop_err <= 8'h00;
        burst_d  <= 1'b0;
    end else begin
        burst_d <= burst_gate;
        phase   <= phase + freq + freq_adj;
        if (burst_gate) begin
            err_acc <= err_acc + v_ext;
        end else if (burst_end) begin
            err_acc  <= 20'h00000;
            freq_adj <= freq_adj - {{12{err_acc[19]}}, err_acc};
            loop_err <= err_acc[17:10];
        end
    end
end

// phase-advance line flag toggles per line in pal only
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        phase_advance_line_flag <= 1'b0;
    end else if (!pal) begin
        phase_advance_line_flag <= 1'b0;
    end else if (field_start) begin
        phase_advance_line_flag <= 1'b0;
    end else if (line_start) begin
        phase_advance_line_flag <= ~phase_advance_line_flag;
    end
end

// ==========================================================
// demodulation, bypasses, filters, coring
wire               dmod_by = ctrl[`CBLD_CTRL_DBYP];
wire signed [10:0] u_src   = dmod_by ? {chroma_in[9], chroma_in} : u_mix;
wire signed [10:0] v_src   = dmod_by ? {cr_in[9], cr_in} : v_mix;
reg  signed [10:0] u_d1;
reg  signed [10:0] u_d2;
reg  signed [10:0] u_d3;
reg  signed [10:0] u_d4;
reg  signed [10:0] v_d1;
reg  signed [10:0] v_d2;
reg  signed [10:0] v_d3;
reg  signed [10:0] v_d4;
wire               fsel    = ctrl[`CBLD_CTRL_FSEL];
wire signed [10:0] u_lpf   = cbld_lpf(fsel, u_src, u_d1, u_d2, u_d3, u_d4);
wire signed [10:0] v_lpf   = cbld_lpf(fsel, v_src, v_d1, v_d2, v_d3, v_d4);
wire signed [10:0] u_flt   = ctrl[`CBLD_CTRL_FBYP] ? u_src : u_lpf;
wire signed [10:0] v_flt   = ctrl[`CBLD_CTRL_FBYP] ? v_src : v_lpf;
wire               core_en = ctrl[`CBLD_CTRL_COREN];

// filter taps and output stage
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        u_d1     <= 11'h000;
        u_d2     <= 11'h000;
        u_d3     <= 11'h000;
        u_d4     <= 11'h000;
        v_d1     <= 11'h000;
        v_d2     <= 11'h000;
        v_d3     <= 11'h000;
        v_d4     <= 11'h000;
        u_out    <= 11'h000;
        v_out    <= 11'h000;
        luma_out <= 10'h000;
    end else begin
        u_d1 <= u_src;
        u_d2 <= u_d1;
        u_d3 <= u_d2;
        u_d4 <= u_d3;
        v_d1 <= v_src;
        v_d2 <= v_d1;
        v_d3 <= v_d2;
        v_d4 <= v_d3;
        if (color_kill_active) begin
            u_out    <= 11'h000;
            v_out    <= 11'h000;
            luma_out <= video_in;
        end else begin
            u_out    <= cbld_core(core_en, core_thr, u_flt);
            v_out    <= cbld_core(core_en, core_thr, v_flt);
            luma_out <= luma_in;
        end
    end
end

// ==========================================================
// color kill detection
reg  [9:0] u_peak;
reg  [9:0] v_peak;
reg  [6:0] kill_count;
wire [10:0] u_mag = cbld_abs(u_mix);
wire [10:0] v_mag = cbld_abs(v_mix);
wire line_kill = (u_peak < {2'b00, blvl}) && (v_peak < {2'b00, blvl});

// burst peaks, burstless line count, kill state
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        u_peak            <= 10'h000;
        v_peak            <= 10'h000;
        kill_count        <= 7'h00;
        color_kill_active <= 1'b0;
    end else begin
        if (burst_gate) begin
            if (u_mag[9:0] > u_peak)
                u_peak <= u_mag[9:0];
            if (v_mag[9:0] > v_peak)
                v_peak <= v_mag[9:0];
        end else if (burst_end) begin
            u_peak <= 10'h000;
            v_peak <= 10'h000;
        end
        if (field_start) begin
            color_kill_active <= (kill_count == `CBLD_KILL_LINES);
            kill_count        <= 7'h00;
        end else if (burst_end && line_kill &&
                     kill_count != `CBLD_KILL_LINES) begin
            kill_count <= kill_count + 7'h01;
        end
    end
end

// ==========================================================
// field sequence identification
wire burst_seen = ~line_kill;

// parity, frame bit and color frame bit
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        field_sequence_count <= 3'b000;
    end else begin
        if (field_start) begin
            field_sequence_count[0] <= vsync_second_half;
            if (!pal) begin
                field_sequence_count[1] <= phase[31];
                field_sequence_count[2] <= 1'b0;
            end else begin
                field_sequence_count[2] <= phase[31];
                if (field_sequence_count[0] && !vsync_second_half)
                    field_sequence_count[1] <= ~field_sequence_count[1];
            end
        end else if (pal && burst_end) begin
            if (!ctrl[`CBLD_CTRL_SET2]) begin
                if (line_count == `CBLD_LINE_309)
                    field_sequence_count[1] <= burst_seen;
            end else if (line_count == `CBLD_LINE_258) begin
                field_sequence_count[1] <= ~burst_seen;
            end else if (line_count == `CBLD_LINE_259) begin
                field_sequence_count[1] <= burst_seen;
            end
        end
    end
end

endmodule
`default_nettype wire

// >>> cbld_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "cbld_map.vh"
// ==========
// port-level checker
module cbld_checker (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic signed [9:0]  chroma_in,
    input wire logic signed [9:0]  cr_in,
    input wire logic [9:0]         video_in,
    input wire logic [9:0]         line_count,
    input wire logic [10:0]        pixel_count,
    input wire logic               vsync_second_half,
    input wire logic [9:0]         luma_out,
    input wire logic signed [10:0] u_out,
    input wire logic signed [10:0] v_out,
    input wire logic [2:0]         field_sequence_count,
    input wire logic               phase_advance_line_flag,
    input wire logic               color_kill_active
);
    logic [7:0] ctrl;
    logic       mapped;
    logic       detect;
    logic       byp;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // control register shadow
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            ctrl <= 8'h00;
        else if (psel && penable && pwrite && pready && paddr == `CBLD_OFF_CTRL)
            ctrl <= pwdata[7:0];
    end
    // decode, field detect and plain pass-through condition
    assign mapped = paddr inside {`CBLD_OFF_CTRL, `CBLD_OFF_FREQ, `CBLD_OFF_HUE0,
        `CBLD_OFF_HUE1, `CBLD_OFF_BLVL, `CBLD_OFF_CORE, `CBLD_OFF_LERR, `CBLD_OFF_STAT};
    assign detect = line_count == 10'h000 && pixel_count == {9'h000, ctrl[7:6]};
    assign byp    = ctrl[2:1] == 2'b11 && !ctrl[4] && !color_kill_active;
    // ==========
    // assertions
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_kill_black: assert property (color_kill_active && $past(color_kill_active)
        |-> u_out == 11'h000 && v_out == 11'h000 && luma_out == $past(video_in))
        else $error("kill output not black");
    a_kill_field: assert property ($changed(color_kill_active) |-> $past(detect))
        else $error("kill changed off field start");
    a_parity_detect: assert property (!$past(sys_rst) && $past(detect)
        |-> field_sequence_count[0] == $past(vsync_second_half))
        else $error("parity not taken at field start");
    a_ntsc_cf_low: assert property (!$past(sys_rst) && $past(detect) && !$past(ctrl[0])
        |-> field_sequence_count[2] == 1'b0)
        else $error("color frame bit high in ntsc");
    a_ntsc_no_adv: assert property ($stable(ctrl[0]) && !ctrl[0] |-> !phase_advance_line_flag)
        else $error("phase advance flag in ntsc");
    a_bypass_pass: assert property (byp && $past(byp) |-> u_out == 11'($past(chroma_in))
        && v_out == 11'($past(cr_in)))
        else $error("bypass path altered chroma");
    // main scenarios
    c_kill: cover property (color_kill_active && $past(color_kill_active));
    c_bypass: cover property (byp && $past(byp));
    c_parity: cover property ($past(detect) && field_sequence_count[0]);
endmodule

bind cbld_top cbld_checker chk (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chroma_in(chroma_in), .cr_in(cr_in), .video_in(video_in), .line_count(line_count),
    .pixel_count(pixel_count), .vsync_second_half(vsync_second_half), .luma_out(luma_out),
    .u_out(u_out), .v_out(v_out), .field_sequence_count(field_sequence_count),
    .phase_advance_line_flag(phase_advance_line_flag), .color_kill_active(color_kill_active)
);
`default_nettype wire

// >>> cbld_source.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// upstream timing and sample source
module cbld_source #(
    parameter LINE_PIX    = 16,
    parameter FIELD_LINES = 312
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        burst_on,
    input  wire logic        second_half,
    output logic [9:0]       line_count,
    output logic [10:0]      pixel_count,
    output logic             burst_gate,
    output logic             active_video,
    output logic [9:0]       chroma_in,
    output logic [9:0]       cr_in,
    output logic [9:0]       luma_in,
    output logic [9:0]       video_in,
    output logic             vsync_second_half
);
    logic       eol;
    logic       in_burst;
    logic [3:0] mix;
    assign eol      = pixel_count == 11'(LINE_PIX - 1);
    assign in_burst = pixel_count >= 11'h001 && pixel_count < 11'h007;
    assign mix      = pixel_count[3:0] ^ line_count[3:0];
    // counts advance; burst, picture chroma and video follow
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_count        <= 10'h000;
            pixel_count       <= 11'h000;
            burst_gate        <= 1'b0;
            active_video      <= 1'b0;
            chroma_in         <= 10'h000;
            cr_in             <= 10'h000;
            luma_in           <= 10'h000;
            video_in          <= 10'h000;
            vsync_second_half <= 1'b0;
        end else begin
            pixel_count <= eol ? 11'h000 : pixel_count + 11'h001;
            if (eol)
                line_count <= (line_count == 10'(FIELD_LINES - 1)) ? 10'h000 : line_count + 10'h001;
            burst_gate   <= in_burst;
            active_video <= pixel_count >= 11'h008 && pixel_count < 11'h00E;
            if (in_burst)
                chroma_in <= !burst_on ? 10'h000 : (pixel_count[1] ? 10'h2D4 : 10'h12C);
            else
                chroma_in <= {6'h00, mix} - 10'h008;
            cr_in             <= 10'h007 - {6'h00, mix};
            luma_in           <= {line_count[5:0], pixel_count[3:0]};
            video_in          <= {pixel_count[3:0], line_count[5:0]};
            vsync_second_half <= second_half;
        end
    end
endmodule
`default_nettype wire

// >>> cbld_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "cbld_map.vh"
// ==========
// bench top
module cbld_bench;
    logic clk, sys_rst, psel, penable, pwrite, burst_all, second_half, e, f;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, r;
    logic               pready, pslverr, burst_gate, active_video, vsh, flag, kill;
    logic [9:0]         line_count, luma_in, video_in, luma_out, drop_line, c, k, y;
    logic [10:0]        pixel_count;
    logic signed [9:0]  chroma_in, cr_in;
    logic signed [10:0] u_out, v_out;
    logic [2:0]         fsc;
    int                 bad_count, compares;
    logic [7:0]  ra [5] = '{`CBLD_OFF_CTRL, `CBLD_OFF_FREQ, `CBLD_OFF_HUE0,
                            `CBLD_OFF_BLVL, `CBLD_OFF_CORE};
    logic [31:0] rv [5] = '{{24'h0, `CBLD_RST_CTRL}, `CBLD_RST_FREQ, {16'h0, `CBLD_RST_HUE},
                            {24'h0, `CBLD_RST_BLVL}, {28'h0, `CBLD_RST_CORE}};
    logic [9:0]  drop [4] = '{`CBLD_LINE_309, 10'h3FF, `CBLD_LINE_258, `CBLD_LINE_259};
    logic        fexp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    cbld_source src (.clk(clk), .sys_rst(sys_rst), .burst_on(burst_all && line_count != drop_line),
        .second_half(second_half), .line_count(line_count), .pixel_count(pixel_count),
        .burst_gate(burst_gate), .active_video(active_video), .chroma_in(chroma_in),
        .cr_in(cr_in), .luma_in(luma_in), .video_in(video_in), .vsync_second_half(vsh));
    cbld_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chroma_in(chroma_in), .cr_in(cr_in), .luma_in(luma_in),
        .video_in(video_in), .line_count(line_count), .pixel_count(pixel_count),
        .burst_gate(burst_gate), .active_video(active_video), .vsync_second_half(vsh),
        .hue_select(1'b0), .luma_out(luma_out), .u_out(u_out), .v_out(v_out),
        .field_sequence_count(fsc), .phase_advance_line_flag(flag), .color_kill_active(kill));
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_pos(input logic [9:0] l, input logic [10:0] p);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(line_count == l && pixel_count == p) && n < 30000);
        if (n >= 30000)
            check("position wait", 32'h1, 32'h0);
        #1;
    endtask
    function automatic logic [10:0] cored(input logic [9:0] x, input logic [3:0] t);
        logic [9:0] mag;
        mag = x[9] ? -x : x;
        cored = (mag < {6'h00, t}) ? 11'h000 : {x[9], x};
    endfunction
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        complete_run();
    end
    // ==========
    // tests
    initial begin
        {psel, penable, pwrite, paddr, pwdata, second_half} = '0;
        burst_all = 1'b1;
        drop_line = 10'h3FF;
        sys_rst   = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(ra[i], 1'b0, 32'h0);
            check("reset value", r, rv[i]);
        end
        apb(8'h20, 1'b1, 32'hFFFF_FFFF);
        apb(8'h20, 1'b0, 32'h0);
        check("unmapped", {31'h0, e}, 32'h1);
        apb(`CBLD_OFF_HUE1, 1'b1, 32'h0000_1234);
        apb(`CBLD_OFF_HUE1, 1'b0, 32'h0);
        check("hue1", r, 32'h0000_1234);
        apb(`CBLD_OFF_BLVL, 1'b1, 32'h0000_0001);
        $display("registers done");
        for (int t = 0; t < 8; t += 4) begin
            apb(`CBLD_OFF_CORE, 1'b1, t);
            apb(`CBLD_OFF_CTRL, 1'b1, (t != 0) ? 32'h16 : 32'h06);
            for (int i = 0; i < 12; i++) begin
                @(posedge clk);
                #1;
                c = chroma_in;
                k = cr_in;
                y = luma_in;
                @(posedge clk);
                #1;
                check("luma_out", {22'h0, luma_out}, {22'h0, y});
                check("u_out", {21'h0, u_out}, {21'h0, cored(c, 4'(t))});
                check("v_out", {21'h0, v_out}, {21'h0, cored(k, 4'(t))});
            end
        end
        $display("bypass and coring done");
        apb(`CBLD_OFF_CTRL, 1'b1, 32'h0);
        burst_all <= 1'b0;
        wait_pos(10'h000, 11'h003);
        second_half <= 1'b1;
        wait_pos(10'h000, 11'h003);
        check("kill on", {31'h0, kill}, 32'h1);
        check("u_out killed", {21'h0, u_out}, 32'h0);
        check("field bits", {29'h0, fsc & 3'b101}, 32'h1);
        apb(`CBLD_OFF_STAT, 1'b0, 32'h0);
        check("status", r & 32'h13, 32'h12);
        apb(`CBLD_OFF_LERR, 1'b0, 32'h0);
        check("loop error", r, 32'h0);
        burst_all   <= 1'b1;
        second_half <= 1'b0;
        wait_pos(10'h000, 11'h003);
        check("kill off", {31'h0, kill}, 32'h0);
        apb(`CBLD_OFF_STAT, 1'b0, 32'h0);
        check("status", r & 32'h13, 32'h01);
        $display("color kill done");
        for (int i = 0; i < 4; i++) begin
            drop_line <= drop[i];
            apb(`CBLD_OFF_CTRL, 1'b1, (i < 2) ? 32'h09 : 32'h29);
            wait_pos(10'h136, 11'h005);
            f = flag;
            wait_pos(10'h137, 11'h005);
            check("advance flag", {31'h0, flag}, {31'h0, ~f});
            check("frame bit", {31'h0, fsc[1]}, {31'h0, fexp[i]});
        end
        $display("pal frame bit done");
        complete_run();
    end
endmodule
`default_nettype wire
